//--- rtl/fms_defs.svh
// Constants for the flyback mode supervisor: times, frequencies, codes.
// Assumes a 100 MHz system clock; times are converted to cycles where used.
`ifndef FMS_DEFS_SVH
`define FMS_DEFS_SVH
// ==========================================
// Clock
`define FMS_CLK_HZ 100000000
`define FMS_CLK_NS 10
// ==========================================
// Switching frequencies and on-time limits
`define FMS_F_NOM65_HZ 65000
`define FMS_F_NOM100_HZ 100000
`define FMS_F_MIN_HZ 27000
`define FMS_TON65_NS 12300
`define FMS_TON100_NS 8000
`define FMS_FOLD_STEP 12'h010
// ==========================================
// Supervisor times in microseconds
`define FMS_TSAMPLE_US 1000
`define FMS_TSS_US 10000
`define FMS_TDROP_US 20000
`define FMS_TGUARD_US 10000
`define FMS_TDET_US 32000
// ==========================================
// Current setpoint codes
`define FMS_SS_STEPS 4'hF
`define FMS_FREEZE_CODE 4'h6
`define FMS_SP_ZERO 4'h0
`endif

//--- rtl/fms_pkg.sv
// Types shared by the flyback mode supervisor and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package fms_pkg;
  typedef enum logic [2:0] {MODE_OFF, MODE_WAIT, MODE_PWM, MODE_FOLD, MODE_SKIP} fms_mode_t;
endpackage

//--- rtl/fms_sync.sv
// Two-flop synchroniser for a vector of comparator flags.
// Assumes each bit changes slowly compared with the clock.
`timescale 1ns/100ps
`default_nettype none
module fms_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_reg <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

//--- rtl/fms_timer.sv
// Up-counting timer: counts while run is high, flags expiry at len.
// Assumes clear has priority and len stays stable during a count.
`timescale 1ns/100ps
`default_nettype none
module fms_timer (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic clear_i,
  input wire logic run_i,
  input wire logic [23:0] len_i,
  output logic expired_o
);
  logic [23:0] cnt_reg;
  logic [23:0] cnt_next;
  always_comb
  begin
    cnt_next = cnt_reg;
    if (clear_i)
      cnt_next = 24'h000000;
    else if (run_i && cnt_reg < len_i)
      cnt_next = cnt_reg + 24'h000001;
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_reg <= 24'h000000;
    else
      cnt_reg <= cnt_next;
  end
  // Expiry does not look at clear: users that clear on their own expiry
  // would otherwise close a combinational loop
  assign expired_o = cnt_reg >= len_i;
endmodule
`default_nettype wire

//--- rtl/fms_supervisor.sv
// Mode selection, startup sequencing, brown-out and unplug discharge
// for an offline flyback controller. Inputs are raw comparator flags
// from the analog front end; reset comes from the supply-low detector.
// Function
// - Feedback below 0.4 V enters off mode
// - Leave off mode only above 2.2 V
// - Off mode keeps feedback watch, discharge and supply source toggling
// - Start in off mode; thermal shutdown holds off
// - Stored fault survives off mode
// - Switch current ends every gate pulse
// - Foldback varies frequency down to 27 kHz
// - Below 1.5 V setpoint frozen constant
// - Lightest loads skip every pulse; period held at 27 kHz
// - Startup source toggles until line start level
// - Start at next turn-on with soft-start
// - Idle switching toggles source within supply window
// - Supply overvoltage latches controller off
// - Short supply uses low current, line gates
// - Brown-out stops, holds supply until line start
// - Stop only after dropout timer expires
// - Line above start allows immediate start
// - Unplug comparator sampled once per period; the code checks its edges every clock and only outputs the strobe
// - Comparator edge restarts timer; expiry means DC
// - DC triggers timed cyclic discharge until stop
// - Unplug detection works in every mode
// - Discharge self-supplies and blocks startup
// - Guard timer filters off mode entry
// - Soft-start in 15 steps, lower setpoint wins
`timescale 1ns/100ps
`default_nettype none
`include "fms_defs.svh"
module fms_supervisor #(
  parameter int SAMPLE_CYC = `FMS_TSAMPLE_US * 1000 / `FMS_CLK_NS,
  parameter int SS_STEP_CYC = `FMS_TSS_US * 1000 / `FMS_CLK_NS / 15,
  parameter int DROP_CYC = `FMS_TDROP_US * 1000 / `FMS_CLK_NS,
  parameter int GUARD_CYC = `FMS_TGUARD_US * 1000 / `FMS_CLK_NS,
  parameter int DET_CYC = `FMS_TDET_US * 1000 / `FMS_CLK_NS
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic freq_100k_i,
  input wire logic fb_off_i,
  input wire logic fb_on_i,
  input wire logic fb_freeze_i,
  input wire logic fb_fold_i,
  input wire logic fb_skip_i,
  input wire logic vcc_on_i,
  input wire logic vcc_restart_i,
  input wire logic vcc_uvlo_i,
  input wire logic vcc_ovp_i,
  input wire logic vcc_short_i,
  input wire logic line_min_i,
  input wire logic line_start_i,
  input wire logic line_stop_i,
  input wire logic thermal_i,
  input wire logic overload_i,
  input wire logic unplug_cmp_i,
  input wire logic cs_trip_i,
  output logic gate_drive_out_o,
  output logic [3:0] setpoint_o,
  output logic hv_source_o,
  output logic hv_low_current_o,
  output logic discharge_o,
  output logic sample_strobe_o,
  output logic dc_detect_o,
  output logic fault_latched_o,
  output fms_pkg::fms_mode_t mode_o
);
  import fms_pkg::*;

  localparam logic [11:0] PER65 = 12'(`FMS_CLK_HZ / `FMS_F_NOM65_HZ);
  localparam logic [11:0] PER100 = 12'(`FMS_CLK_HZ / `FMS_F_NOM100_HZ);
  localparam logic [11:0] PERMIN = 12'(`FMS_CLK_HZ / `FMS_F_MIN_HZ);
  localparam logic [11:0] TON65 = 12'(`FMS_TON65_NS / `FMS_CLK_NS);
  localparam logic [11:0] TON100 = 12'(`FMS_TON100_NS / `FMS_CLK_NS);

  // ==========================================
  // Input synchronisation
  logic fb_off_s, fb_on_s, fb_freeze_s, fb_fold_s, fb_skip_s, vcc_on_s, vcc_restart_s;
  logic vcc_uvlo_s, vcc_ovp_s, vcc_short_s, line_min_s, line_start_s, line_stop_s;
  logic thermal_s, overload_s, cmp_s, cs_s;
  logic [16:0] sync_q;
  fms_sync #(.W(17)) u_sync (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .q_o(sync_q),
    .d_i({fb_off_i, fb_on_i, fb_freeze_i, fb_fold_i, fb_skip_i, vcc_on_i, vcc_restart_i,
          vcc_uvlo_i, vcc_ovp_i, vcc_short_i, line_min_i, line_start_i, line_stop_i,
          thermal_i, overload_i, unplug_cmp_i, cs_trip_i}));
  assign {fb_off_s, fb_on_s, fb_freeze_s, fb_fold_s, fb_skip_s, vcc_on_s, vcc_restart_s,
          vcc_uvlo_s, vcc_ovp_s, vcc_short_s, line_min_s, line_start_s, line_stop_s,
          thermal_s, overload_s, cmp_s, cs_s} = sync_q;

  // ==========================================
  // Timers
  fms_mode_t mode_reg, mode_next;
  logic cmp_d_reg, dc_reg, dc_next, dis_reg, dis_next, line_ok_reg, line_ok_next;
  logic fault_reg, fault_next, src_reg, src_next, gate_reg, gate_next, smp_reg, low_reg, low_next;
  logic [3:0] ss_reg, ss_next, sp_reg, sp_next, sp_fb;
  logic [11:0] per_reg, per_next, cyc_reg, cyc_next, on_reg, on_next, ton_max;
  logic cmp_edge, det_exp, drop_exp, guard_exp, ss_exp, smp_exp, running, wrap;
  assign cmp_edge = cmp_s ^ cmp_d_reg;
  assign running = (mode_reg == MODE_PWM) || (mode_reg == MODE_FOLD) ||
                   (mode_reg == MODE_SKIP);
  // one comparison strobe per sample period
  fms_timer u_sample (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clear_i(smp_exp),
    .run_i(1'b1), .len_i(24'(SAMPLE_CYC - 1)), .expired_o(smp_exp));
  // any comparator edge restarts detection; phase end reloads it
  fms_timer u_detect (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .clear_i(cmp_edge || det_exp || (dc_reg && !line_min_s)), .run_i(1'b1),
    .len_i(24'(DET_CYC)), .expired_o(det_exp));
  // line must stay below stop level for the dropout time
  fms_timer u_drop (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clear_i(!line_stop_s),
    .run_i(line_stop_s), .len_i(24'(DROP_CYC)), .expired_o(drop_exp));
  // feedback must stay low for the guard time
  fms_timer u_guard (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .clear_i(!fb_off_s || mode_reg == MODE_OFF), .run_i(fb_off_s),
    .len_i(24'(GUARD_CYC)), .expired_o(guard_exp));
  fms_timer u_ss (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clear_i(ss_exp || !running),
    .run_i(ss_reg != `FMS_SS_STEPS), .len_i(24'(SS_STEP_CYC - 1)), .expired_o(ss_exp));

  // ==========================================
  // Unplug detector, discharge, line and fault state
  always_comb
  begin
    dc_next = dc_reg;
    dis_next = dis_reg;
    line_ok_next = line_ok_reg;
    fault_next = fault_reg;
    // discharge phases alternate on each timer expiry
    if (dc_reg && det_exp)
      dis_next = !dis_reg;
    // expiry with no edge means DC, in any mode
    if (!dc_reg && det_exp && line_min_s)
    begin
      dc_next = 1'b1;
      dis_next = 1'b1;
    end
    // AC return or low line ends discharge
    if (cmp_edge || !line_min_s)
    begin
      dc_next = 1'b0;
      dis_next = 1'b0;
    end
    // brown-out after dropout time, released at start level
    if (drop_exp)
      line_ok_next = 1'b0;
    if (line_start_s)
      line_ok_next = 1'b1;
    // overvoltage latches; only reset clears it, not off mode
    if (vcc_ovp_s || (overload_s && running))
      fault_next = 1'b1;
  end

  // ==========================================
  // Mode state machine
  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MODE_OFF:
        // wake above the on level, never in thermal shutdown
        if (fb_on_s && !thermal_s)
          mode_next = MODE_WAIT;
      MODE_WAIT:
        // start at next turn-on once line is good, never discharging
        if (line_ok_reg && src_reg && vcc_on_s && !fault_reg && !dc_reg && !vcc_uvlo_s)
          mode_next = MODE_PWM;
      MODE_PWM, MODE_FOLD, MODE_SKIP:
      begin
        // lightest load skips, light load folds back
        if (fb_skip_s)
          mode_next = MODE_SKIP;
        else if (fb_fold_s)
          mode_next = MODE_FOLD;
        else
          mode_next = MODE_PWM;
        // brown-out, fault or supply loss stops switching
        if (!line_ok_reg || fault_reg || vcc_uvlo_s || vcc_ovp_s)
          mode_next = MODE_WAIT;
      end
    endcase
    // guarded low feedback forces off mode
    if (guard_exp || (thermal_s && mode_reg != MODE_OFF))
      mode_next = MODE_OFF;
  end

  // ==========================================
  // Supply source: dynamic self-supply and discharge
  always_comb
  begin
    src_next = src_reg;
    // hysteretic toggle between restart and turn-on levels
    if (vcc_on_s)
      src_next = 1'b0;
    else if (vcc_restart_s || vcc_short_s)
      src_next = 1'b1;
    // Switching supplies itself from the auxiliary winding
    if (mode_next == MODE_PWM || mode_next == MODE_FOLD)
      src_next = 1'b0;
    if (dc_next && (vcc_restart_s || dis_next))
      src_next = 1'b1;
    // a low line keeps the source off over every other condition
    if (!line_min_s)
      src_next = 1'b0;
    // reduced current while the supply is shorted
    low_next = src_next && vcc_short_s && !dis_next;
  end

  // ==========================================
  // Oscillator, gate drive and setpoint
  always_comb
  begin
    ton_max = freq_100k_i ? TON100 : TON65;
    wrap = (cyc_reg >= per_reg - 12'h001);
    cyc_next = wrap ? 12'h000 : cyc_reg + 12'h001;
    per_next = per_reg;
    // stretch period each cycle down to the floor frequency
    if (mode_reg == MODE_FOLD)
    begin
      if (wrap && per_reg < PERMIN - `FMS_FOLD_STEP)
        per_next = per_reg + `FMS_FOLD_STEP;
      else if (wrap)
        per_next = PERMIN;
    end
    else if (mode_reg == MODE_SKIP)
      per_next = PERMIN;
    else
      per_next = freq_100k_i ? PER100 : PER65;
    on_next = gate_reg ? on_reg + 12'h001 : 12'h000;
    gate_next = gate_reg;
    if (wrap && (mode_reg == MODE_PWM || mode_reg == MODE_FOLD))
      gate_next = 1'b1;
    // current or on-time ends a pulse; no gate outside switching
    if (cs_s || on_reg >= ton_max || mode_next == MODE_OFF || mode_next == MODE_WAIT ||
        mode_reg == MODE_SKIP)
      gate_next = 1'b0;
    ss_next = ss_reg;
    if (!running)
      ss_next = `FMS_SP_ZERO;
    else if (ss_exp && ss_reg != `FMS_SS_STEPS)
      ss_next = ss_reg + 4'h1;
    // frozen setpoint below the freeze level
    sp_fb = fb_freeze_s ? `FMS_FREEZE_CODE : `FMS_SS_STEPS;
    // lower of soft-start and feedback setpoints
    sp_next = (ss_reg < sp_fb) ? ss_reg : sp_fb;
    if (!running)
      sp_next = `FMS_SP_ZERO;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode_reg <= MODE_OFF;
      cmp_d_reg <= 1'b0;
      dc_reg <= 1'b0;
      dis_reg <= 1'b0;
      line_ok_reg <= 1'b0;
      fault_reg <= 1'b0;
      src_reg <= 1'b0;
      gate_reg <= 1'b0;
      smp_reg <= 1'b0;
      low_reg <= 1'b0;
      ss_reg <= `FMS_SP_ZERO;
      sp_reg <= `FMS_SP_ZERO;
      per_reg <= PER65;
      cyc_reg <= 12'h000;
      on_reg <= 12'h000;
    end
    else
    begin
      mode_reg <= mode_next;
      cmp_d_reg <= cmp_s;
      dc_reg <= dc_next;
      dis_reg <= dis_next;
      line_ok_reg <= line_ok_next;
      fault_reg <= fault_next;
      src_reg <= src_next;
      gate_reg <= gate_next;
      smp_reg <= smp_exp;
      low_reg <= low_next;
      ss_reg <= ss_next;
      sp_reg <= sp_next;
      per_reg <= per_next;
      cyc_reg <= cyc_next;
      on_reg <= on_next;
    end
  end

  assign gate_drive_out_o = gate_reg;
  assign setpoint_o = sp_reg;
  assign hv_source_o = src_reg;
  assign hv_low_current_o = low_reg;
  assign discharge_o = dis_reg;
  assign sample_strobe_o = smp_reg;
  assign dc_detect_o = dc_reg;
  assign fault_latched_o = fault_reg;
  assign mode_o = mode_reg;

  // ==========================================
  // Assertions
  sequence s_drop_done;
    drop_exp && !line_start_s;
  endsequence
  sequence s_off_held;
    mode_reg == MODE_OFF && !(fb_on_s && !thermal_s);
  endsequence

  a_off_no_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    mode_reg == MODE_OFF |=> !gate_drive_out_o) else $error("gate driven in off mode");
  a_cs_ends_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    gate_reg && cs_s |=> !gate_drive_out_o) else $error("pulse not ended by current");
  a_fault_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    fault_latched_o |=> fault_latched_o) else $error("fault cleared");
  a_ovp_latch: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    vcc_ovp_s |=> fault_reg ##1 mode_reg != MODE_PWM) else $error("overvoltage not latched");
  a_off_exit: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_off_held |=> mode_reg == MODE_OFF) else $error("left off mode early");
  a_brownout_stop: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_drop_done |=> !line_ok_reg) else $error("dropout did not stop");
  a_start_immed: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    line_start_s |=> line_ok_reg) else $error("start level not honoured");
  a_no_start_dc: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    mode_reg == MODE_WAIT && dc_reg |=> mode_reg != MODE_PWM) else $error("start during dc");
  a_low_line_src: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !line_min_s |=> !hv_source_o && !discharge_o) else $error("source on at low line");
  a_skip_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    mode_reg == MODE_SKIP |=> !gate_drive_out_o) else $error("pulse in skip");
  a_ss_limit: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    running && mode_next != MODE_OFF |=> setpoint_o <= $past(ss_reg)) else $error("setpoint high");
  a_edge_clears_dc: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    cmp_edge |=> !dc_detect_o) else $error("dc kept after edge");
endmodule
`default_nettype wire

//--- tb/fms_power_stage.sv
// Behavioural power stage: switch current ramp and line unplug comparator.
// Assumes the gate drive is a registered level on the supervisor clock.
`timescale 1ns/100ps
`default_nettype none
module fms_power_stage #(
  parameter int TRIP_CYC = 10,
  parameter int AC_HALF = 30
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic gate_drive_i,
  input wire logic ac_present_i,
  output logic cs_trip_o,
  output logic unplug_cmp_o
);
  logic [7:0] ramp_reg, ramp_next;
  logic [7:0] ac_cnt_reg, ac_cnt_next;
  logic cmp_reg, cmp_next;
  // ==========================================
  // Switch current and comparator pulses
  always_comb
  begin
    ramp_next = gate_drive_i ? ramp_reg + 8'h01 : 8'h00;
    ac_cnt_next = ac_cnt_reg + 8'h01;
    cmp_next = cmp_reg;
    if (!ac_present_i)
    begin
      // Phase restarts so a returning line toggles AC_HALF+1 cycles later
      cmp_next = 1'b0;
      ac_cnt_next = 8'h00;
    end
    else if (ac_cnt_reg == 8'(AC_HALF))
    begin
      cmp_next = !cmp_reg;
      ac_cnt_next = 8'h00;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ramp_reg <= 8'h00;
      ac_cnt_reg <= 8'h00;
      cmp_reg <= 1'b0;
    end
    else
    begin
      ramp_reg <= ramp_next;
      ac_cnt_reg <= ac_cnt_next;
      cmp_reg <= cmp_next;
    end
  end
  assign cs_trip_o = gate_drive_i && (ramp_reg >= 8'(TRIP_CYC));
  assign unplug_cmp_o = cmp_reg;
endmodule
`default_nettype wire

//--- tb/flyback_mode_supervisor_test.sv
// Self-checking bench for the flyback mode supervisor.
// Assumes shortened timers and the behavioural power stage as partner.
`timescale 1ns/100ps
`default_nettype none
module flyback_mode_supervisor_test;
  import fms_pkg::*;
  logic clk_sys_i, rst_b_i, ac, f100;
  logic fb_off, fb_on, fb_frz, fb_fold, fb_skip, v_on, v_rst, v_uv, v_ovp, v_sh;
  logic l_min, l_start, l_stop, therm, ovl, cmp, trip;
  logic gate, hv_src, hv_low, dis, strobe, dc, fault;
  logic [3:0] sp;
  fms_mode_t mode;
  int errors, compares, i, hi, n;
  fms_supervisor #(.SAMPLE_CYC(20), .SS_STEP_CYC(8), .DROP_CYC(50), .GUARD_CYC(30),
    .DET_CYC(100)) fms_supervisor_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .freq_100k_i(f100), .fb_off_i(fb_off), .fb_on_i(fb_on), .fb_freeze_i(fb_frz),
    .fb_fold_i(fb_fold), .fb_skip_i(fb_skip), .vcc_on_i(v_on), .vcc_restart_i(v_rst),
    .vcc_uvlo_i(v_uv), .vcc_ovp_i(v_ovp), .vcc_short_i(v_sh), .line_min_i(l_min),
    .line_start_i(l_start), .line_stop_i(l_stop), .thermal_i(therm), .overload_i(ovl),
    .unplug_cmp_i(cmp), .cs_trip_i(trip), .gate_drive_out_o(gate), .setpoint_o(sp),
    .hv_source_o(hv_src), .hv_low_current_o(hv_low), .discharge_o(dis),
    .sample_strobe_o(strobe), .dc_detect_o(dc), .fault_latched_o(fault), .mode_o(mode));
  fms_power_stage fms_power_stage_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .gate_drive_i(gate), .ac_present_i(ac), .cs_trip_o(trip), .unplug_cmp_o(cmp));
  // ==========================================
  // Clock and watchdog
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = !clk_sys_i;
  end
  initial
  begin
    repeat (30000) @(posedge clk_sys_i);
    errors++;
    print_verdict();
  end
  // ==========================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_mode(input fms_mode_t m, input int lim);
    i = 0;
    while (mode !== m && i < lim)
    begin
      tick(1);
      i++;
    end
    check("mode", 8'(mode), 8'(m));
  endtask
  // Supply falls to restart level, then climbs back to turn-on level
  task automatic cycle_vcc();
    v_on = 1'b0;
    v_rst = 1'b1;
    v_sh = 1'b1;
    tick(5);
    check("hv_source", 8'(hv_src), 8'h01);
    check("hv_low", 8'(hv_low), 8'h01);
    v_sh = 1'b0;
    v_rst = 1'b0;
    v_on = 1'b1;
    tick(5);
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {fb_off, fb_on, fb_frz, fb_fold, fb_skip, v_on, v_rst, v_uv, v_ovp, v_sh} = '0;
    {l_start, l_stop, therm, ovl} = '0;
    l_min = 1'b1;
    ac = 1'b1;
    f100 = 1'b1;
    rst_b_i = 1'b0;
    errors = 0;
    compares = 0;
    tick(3);
    rst_b_i = 1'b1;
    tick(2);
    check("reset_mode", 8'(mode), 8'(MODE_OFF));
    check("reset_gate", 8'(gate), 8'h00);
    fb_on = 1'b1;
    wait_mode(MODE_WAIT, 10);
    cycle_vcc();
    check("src_off_at_on", 8'(hv_src), 8'h00);
    check("no_start_low_line", 8'(mode), 8'(MODE_WAIT));
    l_start = 1'b1;
    cycle_vcc();
    wait_mode(MODE_PWM, 10);
    check("ss_opens_low", 8'(sp < 4'h4), 8'h01);
    // Gate pulse must be cut by switch current, not by the on-time limit
    i = 0;
    while (gate !== 1'b1 && i < 1100)
    begin
      tick(1);
      i++;
    end
    hi = 0;
    while (gate === 1'b1 && hi < 900)
    begin
      tick(1);
      hi++;
    end
    check("gate_cut_by_trip", 8'(hi > 5 && hi < 20), 8'h01);
    tick(160);
    check("ss_top", 8'(sp), 8'h0F);
    fb_frz = 1'b1;
    tick(5);
    check("freeze", 8'(sp), 8'h06);
    fb_fold = 1'b1;
    wait_mode(MODE_FOLD, 10);
    fb_skip = 1'b1;
    wait_mode(MODE_SKIP, 10);
    tick(2);
    hi = 0;
    repeat (300)
    begin
      tick(1);
      hi += int'(gate === 1'b1);
    end
    check("skip_idle", 8'(hi), 8'h00);
    {fb_frz, fb_fold, fb_skip} = '0;
    wait_mode(MODE_PWM, 10);
    // Brown-out: a short dropout is ridden through, a long one stops
    l_start = 1'b0;
    l_stop = 1'b1;
    tick(20);
    l_stop = 1'b0;
    tick(80);
    check("dropout_ride", 8'(mode), 8'(MODE_PWM));
    l_stop = 1'b1;
    tick(40);
    check("dropout_early", 8'(mode), 8'(MODE_PWM));
    wait_mode(MODE_WAIT, 30);
    l_stop = 1'b0;
    l_start = 1'b1;
    cycle_vcc();
    wait_mode(MODE_PWM, 8);
    // Off mode entry is filtered by the guard timer
    fb_off = 1'b1;
    tick(15);
    fb_off = 1'b0;
    tick(60);
    check("guard_filter", 8'(mode), 8'(MODE_PWM));
    fb_on = 1'b0;
    fb_off = 1'b1;
    tick(20);
    check("guard_early", 8'(mode), 8'(MODE_PWM));
    wait_mode(MODE_OFF, 25);
    hi = 0;
    n = 0;
    repeat (1200)
    begin
      tick(1);
      hi += int'(gate === 1'b1);
      n += int'(strobe === 1'b1);
    end
    check("off_no_gate", 8'(hi), 8'h00);
    check("strobe_rate", 8'(n), 8'h3C);
    fb_off = 1'b0;
    tick(10);
    check("off_holds", 8'(mode), 8'(MODE_OFF));
    // Unplug while in off mode, then try to start during discharge
    ac = 1'b0;
    i = 0;
    while (dc !== 1'b1 && i < 130)
    begin
      tick(1);
      i++;
    end
    check("dc_detect", 8'(dc), 8'h01);
    check("discharge", 8'(dis), 8'h01);
    fb_on = 1'b1;
    v_on = 1'b0;
    tick(5);
    v_on = 1'b1;
    tick(10);
    check("no_start_dis", 8'(mode == MODE_PWM), 8'h00);
    ac = 1'b1;
    tick(40);
    check("dc_clear", 8'(dc), 8'h00);
    check("dis_clear", 8'(dis), 8'h00);
    // Thermal shutdown holds off mode
    fb_on = 1'b0;
    fb_off = 1'b1;
    wait_mode(MODE_OFF, 40);
    therm = 1'b1;
    fb_off = 1'b0;
    fb_on = 1'b1;
    tick(20);
    check("thermal_off", 8'(mode), 8'(MODE_OFF));
    therm = 1'b0;
    wait_mode(MODE_WAIT, 10);
    // Supply overvoltage latches; off mode must not clear it
    f100 = 1'b0;
    cycle_vcc();
    wait_mode(MODE_PWM, 10);
    // 65 kHz option: fall-to-fall gate spacing is one nominal period
    i = 0;
    while (gate !== 1'b1 && i < 1600)
    begin
      tick(1);
      i++;
    end
    while (gate === 1'b1 && i < 1700)
    begin
      tick(1);
      i++;
    end
    hi = 0;
    while (gate !== 1'b1 && hi < 2000)
    begin
      tick(1);
      hi++;
    end
    while (gate === 1'b1 && hi < 2000)
    begin
      tick(1);
      hi++;
    end
    check("period_65k", 8'(hi == 1538), 8'h01);
    v_ovp = 1'b1;
    tick(5);
    v_ovp = 1'b0;
    check("ovp_latch", 8'(fault), 8'h01);
    wait_mode(MODE_WAIT, 5);
    fb_on = 1'b0;
    fb_off = 1'b1;
    wait_mode(MODE_OFF, 40);
    fb_off = 1'b0;
    fb_on = 1'b1;
    wait_mode(MODE_WAIT, 10);
    cycle_vcc();
    tick(10);
    check("fault_kept", 8'(fault), 8'h01);
    check("fault_blocks", 8'(mode), 8'(MODE_WAIT));
    print_verdict();
  end
endmodule
`default_nettype wire
